// ==== logic/omc_top.sv ====
// Low-speed control, status, loopback and management logic of the optical module
module omc_top import omc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Host low-speed inputs, asynchronous
	input wire logic select_inhibit,
	input wire logic transmit_off,
	input wire logic power_down_reset,
	input wire logic reference_clock_pair,
	// Serial management link
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Analog detector levels, asynchronous
	input wire logic tx_pll_locked,
	input wire logic rx_cdr_locked,
	input wire logic rx_power_low,
	// Recovered data words
	input wire logic [DATA_W-1:0] host_tx_data,
	input wire logic [DATA_W-1:0] line_rx_data,
	output logic [DATA_W-1:0] host_rx_data,
	output logic [DATA_W-1:0] line_tx_data,
	// Status outputs
	output logic laser_enable,
	output logic unit_not_ready,
	output logic interrupt_n,
	output logic module_absent,
	output logic receive_signal_lost,
	output logic internal_reset,
	output logic [9:0] line_rate_count
);
	logic [SYNC_W-1:0] sync_bus;
	logic desel_s;
	logic txoff_s;
	logic pdown_s;
	logic ref_s;
	logic scl_s;
	logic sda_s;
	logic txlock_s;
	logic rxlock_s;
	logic rxlow_s;
	logic [7:0] reg_ptr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic wr_en;
	logic rd_en;

	// All asynchronous levels pass two flip-flops first
	omc_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({select_inhibit, transmit_off, power_down_reset, reference_clock_pair,
			scl, sda_in, tx_pll_locked, rx_cdr_locked, rx_power_low}),
		.sync_out(sync_bus)
	);
	assign {desel_s, txoff_s, pdown_s, ref_s, scl_s, sda_s, txlock_s, rxlock_s, rxlow_s}
		= sync_bus;

	// Strobes from the serial slave name the register they act on
	omc_twi_slave u_twi (
		.clk(clk),
		.sys_rst(sys_rst),
		.scl(scl_s),
		.sda(sda_s),
		.deselect(desel_s),
		.sda_oe(sda_oe),
		.reg_ptr(reg_ptr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data)
	);

	// Reset pulse from the power-down pin
	logic pdown_q;
	logic next_pdown_q;
	logic next_internal_reset;
	logic soft_rst;
	assign soft_rst = internal_reset;

	always_comb begin
		next_pdown_q = pdown_s;
		next_internal_reset = pdown_q & ~pdown_s;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pdown_q <= 1'b0;
			internal_reset <= 1'b0;
		end else begin
			pdown_q <= next_pdown_q;
			internal_reset <= next_internal_reset;
		end
	end

	// Reference clock edge count per window sets line rate and lock check
	logic ref_q;
	logic next_ref_q;
	logic [9:0] ref_edges;
	logic [9:0] next_ref_edges;
	logic [9:0] next_rate;
	logic [9:0] window_cnt;
	logic [9:0] next_window_cnt;
	logic ref_ok;
	logic next_ref_ok;

	always_comb begin
		next_ref_q = ref_s;
		next_ref_edges = ref_edges;
		next_window_cnt = window_cnt + 10'h001;
		next_rate = line_rate_count;
		next_ref_ok = ref_ok;
		// Count rising edges of the synchronised level
		if (ref_s && !ref_q) begin
			next_ref_edges = ref_edges + 10'h001;
		end
		if (window_cnt == 10'(REF_WINDOW_CYCLES - 1)) begin
			next_window_cnt = 10'h000;
			next_ref_edges = 10'h000;
			next_rate = ref_edges;
			next_ref_ok = (ref_edges >= REF_EDGES_MIN) && (ref_edges <= REF_EDGES_MAX);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || soft_rst) begin
			ref_q <= 1'b0;
			ref_edges <= 10'h000;
			window_cnt <= 10'h000;
			line_rate_count <= 10'h000;
			ref_ok <= 1'b0;
		end else begin
			ref_q <= next_ref_q;
			ref_edges <= next_ref_edges;
			window_cnt <= next_window_cnt;
			line_rate_count <= next_rate;
			ref_ok <= next_ref_ok;
		end
	end

	// Relock hold after any reset
	logic [7:0] relock_cnt;
	logic [7:0] next_relock_cnt;
	logic tx_alarm;
	logic rx_unlock;
	logic relocking;
	assign tx_alarm = ~txlock_s | ~ref_ok;
	assign rx_unlock = ~rxlock_s;
	assign relocking = relock_cnt != 8'h00;

	always_comb begin
		next_relock_cnt = relock_cnt;
		if (!tx_alarm && !rx_unlock && relocking) begin
			next_relock_cnt = relock_cnt - 8'h01;
		end else if (tx_alarm || rx_unlock) begin
			// A loss while pending restarts the hold; once zero it stays zero
			next_relock_cnt = relocking ? 8'(RELOCK_CYCLES) : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || soft_rst) begin
			relock_cnt <= 8'(RELOCK_CYCLES);
		end else begin
			relock_cnt <= next_relock_cnt;
		end
	end

	// Sticky interrupt causes, mask and loopback control
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [7:0] flags_seen;
	logic [7:0] next_flags_seen;
	logic [7:0] mask;
	logic [7:0] next_mask;
	logic [7:0] control;
	logic [7:0] next_control;
	logic [7:0] cond;
	logic [7:0] cond_q;
	logic [7:0] next_cond_q;
	logic [7:0] rise;
	logic [7:0] clr;
	logic next_not_ready;
	logic next_int_n;
	logic next_los;

	always_comb begin
		cond = 8'h00;
		cond[BIT_TX_ALARM] = tx_alarm;
		cond[BIT_RECEIVE_SIGNAL_LOST] = rxlow_s;
		cond[BIT_RX_UNLOCK] = rx_unlock;
		cond[BIT_REF_BAD] = ~ref_ok;
		next_cond_q = cond;
		rise = cond & ~cond_q;
		next_flags_seen = flags;
		// Clear only what the read loaded; a flag set since then stays
		clr = (rd_en && reg_ptr == REG_FLAGS) ? flags_seen : 8'h00;
		next_flags = (flags & ~clr) | rise;
		next_mask = mask;
		next_control = control;
		if (wr_en && reg_ptr == REG_MASK) begin
			next_mask = wr_data;
		end
		if (wr_en && reg_ptr == REG_CONTROL) begin
			next_control = wr_data & 8'h03;
		end
		next_not_ready = tx_alarm | rx_unlock | rxlow_s | relocking;
		next_int_n = ~|(next_flags & mask);
		next_los = rxlow_s;
	end

	always_ff @(posedge clk) begin
		if (sys_rst || soft_rst) begin
			flags <= FLAGS_RESET;
			flags_seen <= FLAGS_RESET;
			mask <= MASK_RESET;
			control <= CONTROL_RESET;
			cond_q <= 8'h00;
			unit_not_ready <= 1'b1;
			interrupt_n <= 1'b1;
			receive_signal_lost <= 1'b0;
		end else begin
			flags <= next_flags;
			flags_seen <= next_flags_seen;
			mask <= next_mask;
			control <= next_control;
			cond_q <= next_cond_q;
			unit_not_ready <= next_not_ready;
			interrupt_n <= next_int_n;
			receive_signal_lost <= next_los;
		end
	end

	// Read data for the serial slave
	always_comb begin
		rd_data = 8'h00;
		case (reg_ptr)
			REG_STATUS: begin
				rd_data[BIT_TX_ALARM] = tx_alarm;
				rd_data[BIT_RECEIVE_SIGNAL_LOST] = rxlow_s;
				rd_data[BIT_RX_UNLOCK] = rx_unlock;
				rd_data[BIT_REF_BAD] = ~ref_ok;
				rd_data[BIT_NOT_READY] = unit_not_ready;
				rd_data[BIT_RELOCK] = relocking;
				rd_data[BIT_TX_OFF] = txoff_s;
			end
			REG_FLAGS: rd_data = flags;
			REG_MASK: rd_data = mask;
			REG_CONTROL: rd_data = control;
			REG_RATE: rd_data = line_rate_count[9:2];
			default: rd_data = 8'h00;
		endcase
	end

	// Loopback data paths and transmitter control; pdown level is not a disable
	logic [DATA_W-1:0] next_host_rx;
	logic [DATA_W-1:0] next_line_tx;
	logic next_laser;

	always_comb begin
		next_host_rx = control[BIT_SYS_LOOP] ? host_tx_data : line_rx_data;
		next_line_tx = control[BIT_NET_LOOP] ? line_rx_data : host_tx_data;
		next_laser = ~txoff_s;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_rx_data <= '0;
			line_tx_data <= '0;
			laser_enable <= 1'b0;
			module_absent <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			host_rx_data <= next_host_rx;
			line_tx_data <= next_line_tx;
			laser_enable <= next_laser;
			module_absent <= 1'b0;
			sda_out <= 1'b0;
		end
	end
endmodule

// ==== logic/omc_pkg.sv ====
// Shared constants, register map and state codes of the module status and control block
package omc_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RELOCK_TIME_NS = 10000;
	localparam int RELOCK_CYCLES = (RELOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_WINDOW_NS = 100000;
	localparam int REF_WINDOW_CYCLES = REF_WINDOW_NS / CLK_PERIOD_NS;
	localparam logic [9:0] REF_EDGES_MIN = 10'h0C8;
	localparam logic [9:0] REF_EDGES_MAX = 10'h1F4;
	// Data path and synchroniser widths
	localparam int DATA_W = 16;
	localparam int SYNC_W = 9;
	// Serial management address, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h2A;
	// Register offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_FLAGS = 8'h01;
	localparam logic [7:0] REG_MASK = 8'h02;
	localparam logic [7:0] REG_CONTROL = 8'h03;
	localparam logic [7:0] REG_RATE = 8'h04;
	// Field positions
	localparam int BIT_SYS_LOOP = 0;
	localparam int BIT_NET_LOOP = 1;
	localparam int BIT_TX_ALARM = 0;
	localparam int BIT_RECEIVE_SIGNAL_LOST = 1;
	localparam int BIT_RX_UNLOCK = 2;
	localparam int BIT_REF_BAD = 3;
	localparam int BIT_NOT_READY = 4;
	localparam int BIT_RELOCK = 5;
	localparam int BIT_TX_OFF = 6;
	// Values after reset
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h0F;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// Serial slave states
	typedef enum logic [3:0] {
		TWI_IDLE = 4'h0,
		TWI_ADDR = 4'h1,
		TWI_ADDR_ACK = 4'h2,
		TWI_REG = 4'h3,
		TWI_REG_ACK = 4'h4,
		TWI_WDATA = 4'h5,
		TWI_WDATA_ACK = 4'h6,
		TWI_RDATA = 4'h7,
		TWI_RDATA_ACK = 4'h8
	} omc_twi_state_type;
endpackage

// ==== logic/omc_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous levels
module omc_sync import omc_pkg::*; #(
	parameter int WIDTH = SYNC_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule

// ==== logic/omc_twi_slave.sv ====
// Two-wire serial management slave with register pointer, oversampled on clk
module omc_twi_slave import omc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Synchronised link levels
	input wire logic scl,
	input wire logic sda,
	input wire logic deselect,
	output logic sda_oe,
	// Register access
	output logic [7:0] reg_ptr,
	output logic [7:0] wr_data,
	output logic wr_en,
	output logic rd_en,
	input wire logic [7:0] rd_data
);
	omc_twi_state_type state, next_state;
	logic [7:0] shift, next_shift;
	logic [3:0] cnt, next_cnt;
	logic [7:0] next_ptr, next_wr_data;
	logic next_oe, next_wr_en, next_rd_en;
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, start_cond, stop_cond;

	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign start_cond = scl & scl_q & sda_q & ~sda;
	assign stop_cond = scl & scl_q & ~sda_q & sda;

	always_comb begin
		next_state = state;
		next_shift = shift;
		next_cnt = cnt;
		next_ptr = reg_ptr;
		next_wr_data = wr_data;
		next_oe = sda_oe;
		next_wr_en = 1'b0;
		next_rd_en = 1'b0;
		// Pointer moves on after the read strobe, so the strobe names the register read
		if (rd_en) begin
			next_ptr = reg_ptr + 8'h01;
		end
		if (deselect) begin
			next_state = TWI_IDLE;
			next_oe = 1'b0;
		end else if (start_cond) begin
			next_state = TWI_ADDR;
			next_cnt = 4'h0;
			next_oe = 1'b0;
		end else if (stop_cond) begin
			next_state = TWI_IDLE;
			next_oe = 1'b0;
		end else begin
			case (state)
				TWI_ADDR, TWI_REG, TWI_WDATA: begin
					if (scl_rise) begin
						next_shift = {shift[6:0], sda};
						next_cnt = cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						next_oe = 1'b1;
						if (state == TWI_ADDR) begin
							if (shift[7:1] == DEV_ADDR) begin
								next_state = TWI_ADDR_ACK;
							end else begin
								next_state = TWI_IDLE;
								next_oe = 1'b0;
							end
						end else if (state == TWI_REG) begin
							next_ptr = shift;
							next_state = TWI_REG_ACK;
						end else begin
							next_wr_data = shift;
							next_wr_en = 1'b1;
							next_state = TWI_WDATA_ACK;
						end
					end
				end
				TWI_ADDR_ACK, TWI_REG_ACK, TWI_WDATA_ACK: begin
					if (scl_fall) begin
						next_cnt = 4'h0;
						next_oe = 1'b0;
						if (state == TWI_ADDR_ACK && shift[0]) begin
							next_shift = rd_data;
							next_oe = ~rd_data[7];
							next_rd_en = 1'b1;
							next_state = TWI_RDATA;
						end else if (state == TWI_ADDR_ACK) begin
							next_state = TWI_REG;
						end else begin
							if (state == TWI_WDATA_ACK) begin
								next_ptr = reg_ptr + 8'h01;
							end
							next_state = TWI_WDATA;
						end
					end
				end
				TWI_RDATA: begin
					if (scl_rise) begin
						next_cnt = cnt + 4'h1;
					end else if (scl_fall) begin
						if (cnt == 4'h8) begin
							next_oe = 1'b0;
							next_state = TWI_RDATA_ACK;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_oe = ~shift[6];
						end
					end
				end
				TWI_RDATA_ACK: begin
					if (scl_rise) begin
						next_shift = {shift[7:1], sda};
					end else if (scl_fall) begin
						if (shift[0]) begin
							next_state = TWI_IDLE;
						end else begin
							next_shift = rd_data;
							next_oe = ~rd_data[7];
							next_rd_en = 1'b1;
							next_cnt = 4'h0;
							next_state = TWI_RDATA;
						end
					end
				end
				default: begin
					next_state = TWI_IDLE;
					next_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= TWI_IDLE;
			shift <= 8'h00;
			cnt <= 4'h0;
			reg_ptr <= 8'h00;
			wr_data <= 8'h00;
			sda_oe <= 1'b0;
			wr_en <= 1'b0;
			rd_en <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			state <= next_state;
			shift <= next_shift;
			cnt <= next_cnt;
			reg_ptr <= next_ptr;
			wr_data <= next_wr_data;
			sda_oe <= next_oe;
			wr_en <= next_wr_en;
			rd_en <= next_rd_en;
			scl_q <= scl;
			sda_q <= sda;
		end
	end
endmodule

// ==== sim/omc_host.sv ====
// Host controller model: two-wire master and free-running reference
module omc_host import omc_pkg::*; (
	// Clock
	input wire logic clk,
	// Two-wire link
	input wire logic sda_oe,
	input wire logic sda_out,
	output logic scl,
	output logic sda_line,
	// Reference indicator
	output logic ref_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pull_low = 1'b0;
	logic [1:0] ref_div = 2'h0;
	// Open-drain line with pull-up
	assign sda_line = !(pull_low || (sda_oe && !sda_out));
	// One rising edge every four cycles
	assign ref_clk = ref_div[1];
	initial scl = 1'b1;
	always @(negedge clk) ref_div <= ref_div + 2'h1;
	task automatic half();
		repeat (10) @(negedge clk);
	endtask
	// SDA moves only while SCL is low
	task automatic put_bit(input logic b, output logic seen);
		half();
		pull_low = !b;
		half();
		scl = 1'b1;
		half();
		half();
		seen = sda_line;
		scl = 1'b0;
	endtask
	// Start, or repeated start, or a stop
	task automatic edge_pair(input logic stop);
		half();
		pull_low = stop;
		half();
		scl = 1'b1;
		half();
		pull_low = !stop;
		half();
		if (!stop)
			scl = 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] v, output logic [7:0] got, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(v[i], got[i]);
		put_bit(1'b1, s);
		ack = !s;
	endtask
	// Pointer write, then a data byte or a repeated start and one read byte
	task automatic access(input logic [7:0] ptr, input logic rd, input logic [7:0] wv,
		output logic [7:0] rv, output logic acked);
		logic [7:0] g;
		logic a0, a1, a2;
		edge_pair(1'b0);
		put_byte({DEV_ADDR, 1'b0}, g, a0);
		put_byte(ptr, g, a1);
		rv = 8'h00;
		if (rd) begin
			edge_pair(1'b0);
			put_byte({DEV_ADDR, 1'b1}, g, a2);
			put_byte(8'hFF, rv, g[0]);
		end else begin
			put_byte(wv, g, a2);
		end
		edge_pair(1'b1);
		acked = a0 && a1 && a2;
	endtask
endmodule

// ==== sim/omc_assertions.sv ====
// Concurrent checks on the ports of the status and control block
module omc_assertions import omc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Host inputs
	input wire logic select_inhibit,
	input wire logic transmit_off,
	input wire logic power_down_reset,
	input wire logic tx_pll_locked,
	input wire logic rx_cdr_locked,
	input wire logic rx_power_low,
	input wire logic [DATA_W-1:0] host_tx_data,
	input wire logic [DATA_W-1:0] line_rx_data,
	// Module outputs
	input wire logic [DATA_W-1:0] host_rx_data,
	input wire logic sda_oe,
	input wire logic laser_enable,
	input wire logic unit_not_ready,
	input wire logic module_absent,
	input wire logic receive_signal_lost,
	input wire logic internal_reset
);
	logic [2:0] live;
	logic [2:0] next_live;
	logic ok;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Cycles since reset release, so pipelines are filled
	always_comb begin
		next_live = live;
		if (live != 3'h7)
			next_live = live + 3'h1;
		if (sys_rst)
			next_live = 3'h0;
	end
	always_ff @(posedge clk) begin
		live <= next_live;
	end
	assign ok = (live == 3'h7);
	a_laser_follow: assert property (ok |-> laser_enable == !$past(transmit_off, 3))
		else $error("laser enable does not follow transmit off");
	a_los_follow: assert property (ok |-> receive_signal_lost == $past(rx_power_low, 3))
		else $error("signal lost does not follow receive power");
	a_host_rx_src: assert property (
		ok |-> host_rx_data == $past(host_tx_data) || host_rx_data == $past(line_rx_data))
		else $error("host receive word has no source");
	a_nr_tx_lock: assert property (!tx_pll_locked [*6] |-> unit_not_ready)
		else $error("not ready low while transmit lock lost");
	a_nr_rx_fault: assert property ((!rx_cdr_locked || rx_power_low) [*6] |-> unit_not_ready)
		else $error("not ready low while receive fault");
	a_pulse_delay: assert property ($fell(power_down_reset) |-> ##3 internal_reset)
		else $error("no reset pulse after power down fall");
	a_pulse_single: assert property (internal_reset |=> !internal_reset)
		else $error("reset pulse longer than one cycle");
	a_high_no_reset: assert property (power_down_reset [*6] |-> !internal_reset)
		else $error("reset pulse while power down held high");
	a_relock_nr: assert property (internal_reset |-> ##4 unit_not_ready [*8])
		else $error("not ready not shown after reset");
	a_desel_quiet: assert property (select_inhibit [*6] |-> !sda_oe)
		else $error("data line pulled while deselected");
	a_absent_low: assert property (!module_absent)
		else $error("absent output high");
	c_reset_pulse: cover property (internal_reset);
	c_ack: cover property (sda_oe);
	c_laser_off: cover property ($fell(laser_enable));
endmodule
bind omc_top omc_assertions u_chk (.clk, .sys_rst, .select_inhibit, .transmit_off,
	.power_down_reset, .tx_pll_locked, .rx_cdr_locked, .rx_power_low, .host_tx_data,
	.line_rx_data, .host_rx_data, .sda_oe, .laser_enable, .unit_not_ready, .module_absent,
	.receive_signal_lost, .internal_reset);

// ==== sim/test_optical_module_status_control.sv ====
// Self-checking bench of the optical module status and control block
module test_optical_module_status_control import omc_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic select_inhibit = 1'b0;
	logic transmit_off = 1'b0;
	logic power_down_reset = 1'b0;
	logic tx_pll_locked = 1'b1;
	logic rx_cdr_locked = 1'b1;
	logic rx_power_low = 1'b0;
	logic [DATA_W-1:0] host_tx_data = '0;
	logic [DATA_W-1:0] line_rx_data = '0;
	logic [DATA_W-1:0] host_rx_data, line_tx_data;
	logic scl, sda_line, sda_out, sda_oe, ref_clk, laser_enable, unit_not_ready, interrupt_n;
	logic module_absent, receive_signal_lost, internal_reset, acked;
	logic [9:0] line_rate_count;
	logic [7:0] rv;
	logic [2:0] hist;
	int n_errors = 0;
	int checks = 0;
	int seed = 32'h287F4214;
	int pulses;
	omc_top uut (.clk, .sys_rst, .select_inhibit, .transmit_off, .power_down_reset,
		.reference_clock_pair(ref_clk), .scl, .sda_in(sda_line), .sda_out, .sda_oe,
		.tx_pll_locked, .rx_cdr_locked, .rx_power_low, .host_tx_data, .line_rx_data,
		.host_rx_data, .line_tx_data, .laser_enable, .unit_not_ready, .interrupt_n,
		.module_absent, .receive_signal_lost, .internal_reset, .line_rate_count);
	omc_host u_host (.clk, .sda_oe, .sda_out, .scl, .sda_line, .ref_clk);
	initial begin
		forever #50 clk = !clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic xfer(input logic [7:0] a, input logic r, input logic [7:0] v);
		u_host.access(a, r, v, rv, acked);
		check(acked, 1'b1);
	endtask
	// Expected host receive word in the upper half, line transmit word below
	function automatic logic [31:0] loop_exp(input logic [1:0] m, input logic [15:0] h,
		input logic [15:0] l);
		return {m[0] ? h : l, m[1] ? l : h};
	endfunction
	task automatic data_run(input logic [1:0] mode);
		logic [31:0] want;
		hist = {3{transmit_off}};
		repeat (24) begin
			host_tx_data = 16'($random(seed));
			line_rx_data = 16'($random(seed));
			transmit_off = 1'($random(seed));
			hist = {hist[1:0], transmit_off};
			want = loop_exp(mode, host_tx_data, line_rx_data);
			cycles(1);
			check({host_rx_data, line_tx_data}, want);
			check(laser_enable, !hist[2]);
		end
	endtask
	initial begin
		cycles(6);
		check({unit_not_ready, interrupt_n, module_absent, sda_oe, internal_reset}, 5'h18);
		sys_rst = 1'b0;
		cycles(2100);
		check(unit_not_ready, 1'b0);
		check(line_rate_count, 10'h0FA);
		xfer(REG_RATE, 1'b1, 8'h00);
		check(rv, 8'h3E);
		xfer(REG_MASK, 1'b1, 8'h00);
		check(rv, MASK_RESET);
		xfer(REG_FLAGS, 1'b1, 8'h00);
		for (int m = 0; m < 4; m++) begin
			xfer(REG_CONTROL, 1'b0, 8'(m) | 8'hFC);
			xfer(REG_CONTROL, 1'b1, 8'h00);
			check(rv, 8'(m));
			data_run(2'(m));
		end
		// Deselected write must be ignored
		select_inhibit = 1'b1;
		cycles(10);
		u_host.access(REG_CONTROL, 1'b0, 8'h01, rv, acked);
		check(acked, 1'b0);
		select_inhibit = 1'b0;
		cycles(10);
		xfer(REG_CONTROL, 1'b1, 8'h00);
		check(rv, 8'h03);
		xfer(8'h10, 1'b0, 8'h5A);
		xfer(8'h10, 1'b1, 8'h00);
		check(rv, 8'h00);
		check(interrupt_n, 1'b1);
		rx_power_low = 1'b1;
		cycles(10);
		check({receive_signal_lost, unit_not_ready, interrupt_n}, 3'h6);
		xfer(REG_STATUS, 1'b1, 8'h00);
		check(rv, {1'b0, transmit_off, 6'h12});
		xfer(REG_FLAGS, 1'b1, 8'h00);
		check(rv, 8'h02);
		cycles(5);
		check(interrupt_n, 1'b1);
		// Masked event stays silent until unmasked
		xfer(REG_MASK, 1'b0, 8'h00);
		rx_power_low = 1'b0;
		cycles(10);
		rx_power_low = 1'b1;
		cycles(10);
		check(interrupt_n, 1'b1);
		rx_power_low = 1'b0;
		xfer(REG_MASK, 1'b0, 8'h0F);
		check(interrupt_n, 1'b0);
		xfer(REG_FLAGS, 1'b1, 8'h00);
		check(rv, 8'h02);
		for (int k = 0; k < 2; k++) begin
			{tx_pll_locked, rx_cdr_locked} = k ? 2'h2 : 2'h1;
			cycles(10);
			check(unit_not_ready, 1'b1);
			{tx_pll_locked, rx_cdr_locked} = 2'h3;
			cycles(10);
			check(unit_not_ready, 1'b0);
		end
		power_down_reset = 1'b1;
		cycles(50);
		check({internal_reset, laser_enable}, {1'b0, !transmit_off});
		power_down_reset = 1'b0;
		pulses = 0;
		repeat (20) begin
			cycles(1);
			pulses += internal_reset;
		end
		check(pulses, 1);
		check(unit_not_ready, 1'b1);
		xfer(REG_CONTROL, 1'b1, 8'h00);
		check(rv, CONTROL_RESET);
		xfer(REG_MASK, 1'b1, 8'h00);
		check(rv, MASK_RESET);
		cycles(1200);
		check(unit_not_ready, 1'b0);
		tally_and_finish();
	end
	initial begin
		#(60000 * 100);
		n_errors++;
		tally_and_finish();
	end
endmodule
